// File: dbg_event_unit.sv
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module dbg_event_unit #(
   parameter int pc_width = 32
) (
   input wire logic clk,
   input wire logic resetn,
   // Avalon-MM slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Storage access from load/store pipe
   input wire logic acc_valid,
   input wire logic acc_is_write,
   input wire logic [1:0] acc_offset,
   input wire logic [2:0] acc_len,
   input wire logic [31:0] acc_data,
   input wire logic acc_addr_hit_a,
   input wire logic acc_addr_hit_b,
   input wire logic acc_cache_op,
   input wire logic acc_cache_zero,
   input wire logic acc_store_cond,
   input wire logic acc_reservation,
   input wire logic acc_string_idx,
   input wire logic [6:0] string_byte_count,
   // Instruction outcomes
   input wire logic [pc_width-1:0] ins_pc,
   input wire logic branch_taken,
   input wire logic trap_word_op,
   // Debug action outputs
   output logic suppress,
   output logic stop_req,
   output logic [pc_width-1:0] stop_pc,
   output logic dbg_irq,
   output logic prog_trap_irq,
   output logic [pc_width-1:0] critical_save_pc,
   output logic trace_valid,
   output logic [2:0] trace_code
);
   import dbg_event_pkg::*;

   // ****************************************************************
   // Register state
   // ****************************************************************
   logic [5:0] debug_ctrl_zero_q;
   logic [12:0] debug_ctrl_two_q;
   logic [31:0] value_cmp_reg_a_q;
   logic [31:0] value_cmp_reg_b_q;
   logic [6:0] debug_status_reg_q;
   logic dbg_irq_allow_q;
   logic allow_prev_q;
   logic wait_q;
   logic [31:0] rdata_q;
   logic suppress_q;
   logic stop_req_q;
   logic [pc_width-1:0] stop_pc_q;
   logic dbg_irq_q;
   logic prog_trap_q;
   logic [pc_width-1:0] csave_q;
   logic trace_valid_q;
   logic [2:0] trace_code_q;

   // Named views of the control fields
   logic [3:0] value_cmp_lane_mask_a;
   logic [3:0] value_cmp_lane_mask_b;
   logic [1:0] value_cmp_mode_sel_a;
   logic [1:0] value_cmp_mode_sel_b;
   logic async_addr_cmp_sel;
   logic dbg_mode;
   logic int_only;
   logic trace_only;

   assign value_cmp_lane_mask_a = debug_ctrl_two_q[mask_a_lsb +: 4];
   assign value_cmp_lane_mask_b = debug_ctrl_two_q[mask_b_lsb +: 4];
   assign value_cmp_mode_sel_a = debug_ctrl_two_q[mode_a_lsb +: 2];
   assign value_cmp_mode_sel_b = debug_ctrl_two_q[mode_b_lsb +: 2];
   assign async_addr_cmp_sel = debug_ctrl_two_q[async_sel_bit];

   // Mode precedence: external/wait over internal over trace
   assign dbg_mode = debug_ctrl_zero_q[ext_mode_bit] | debug_ctrl_zero_q[wait_mode_bit];
   assign int_only = debug_ctrl_zero_q[int_mode_bit] & ~dbg_mode;
   assign trace_only = debug_ctrl_zero_q[trace_mode_bit] & ~dbg_mode
                       & ~debug_ctrl_zero_q[int_mode_bit];

   // ****************************************************************
   // Value compare
   // ****************************************************************
   // Lane k (0 = MSB) sits at vector bit 3-k, matching mask field order
   function automatic logic lane_match(input logic [1:0] mode, input logic [3:0] mask,
                                       input logic [3:0] hit);
      logic [3:0] miss;
      logic res;
      miss = mask & ~hit;
      res = 1'b0;
      case (mode)
         mode_and: res = (mask != 4'h0) && (miss == 4'h0);
         mode_or: res = |(mask & hit);
         // Empty pair never passes, so a lone pair cannot match by default
         mode_and_or: res = ((mask[3:2] != 2'b00) && (miss[3:2] == 2'b00))
                            || ((mask[1:0] != 2'b00) && (miss[1:0] == 2'b00));
         mode_off: res = 1'b0;
         default: res = 1'b0;
      endcase
      return res;
   endfunction

   logic [3:0] acc_lanes;
   logic [3:0] hit_a;
   logic [3:0] hit_b;
   logic [31:0] cmp_data;
   logic acc_ok;
   logic acc_wr;
   logic vc_a;
   logic vc_b;

   // Lanes sent within the aligned word holding the starting byte
   always_comb begin
      logic [3:0] end_lane;
      end_lane = {2'b00, acc_offset} + {1'b0, acc_len} - 4'h1;
      for (int k = 0; k < 4; k++) begin
         acc_lanes[3-k] = (4'(k) >= {2'b00, acc_offset}) && (4'(k) <= end_lane);
      end
      // Cache-line-zero writes zeroes over every lane of each word
      if (acc_cache_zero) begin
         acc_lanes = 4'hf;
      end
   end

   assign cmp_data = acc_cache_zero ? 32'h0000_0000 : acc_data;
   assign acc_wr = acc_is_write | acc_cache_zero;

   // Qualify the access; other cache ops, failed stores, empty strings drop out
   assign acc_ok = acc_valid
                   & ~(acc_cache_op & ~acc_cache_zero)
                   & ~(acc_store_cond & ~acc_reservation)
                   & ~(acc_string_idx & (string_byte_count == 7'h00));

   always_comb begin
      for (int k = 0; k < 4; k++) begin
         hit_a[3-k] = acc_lanes[3-k]
                      && (cmp_data[31-8*k -: 8] == value_cmp_reg_a_q[31-8*k -: 8]);
         hit_b[3-k] = acc_lanes[3-k]
                      && (cmp_data[31-8*k -: 8] == value_cmp_reg_b_q[31-8*k -: 8]);
      end
   end

   // Judged per access cycle, so split accesses are evaluated apart
   assign vc_a = acc_ok & acc_addr_hit_a & (value_cmp_lane_mask_a != 4'h0)
                 & lane_match(value_cmp_mode_sel_a, value_cmp_lane_mask_a, hit_a);
   assign vc_b = acc_ok & acc_addr_hit_b & (value_cmp_lane_mask_b != 4'h0)
                 & lane_match(value_cmp_mode_sel_b, value_cmp_lane_mask_b, hit_b);

   // ****************************************************************
   // Event qualification
   // ****************************************************************
   logic any_mode;
   logic vc_ev;
   logic brt_ev;
   logic trap_ev;
   logic ev_any;
   logic ev_supp;
   logic delayed_irq;
   logic [6:0] status_set;

   assign any_mode = dbg_mode | debug_ctrl_zero_q[int_mode_bit] | trace_only;
   assign vc_ev = (vc_a | vc_b) & any_mode;
   assign brt_ev = debug_ctrl_zero_q[brt_en_bit] & branch_taken
                   & (dbg_mode | (int_only & dbg_irq_allow_q) | trace_only);
   assign trap_ev = debug_ctrl_zero_q[trap_en_bit] & trap_word_op & any_mode;
   assign ev_any = vc_ev | brt_ev | trap_ev;

   // Synchronous value events stop the access; asynchronous ones let it finish
   assign ev_supp = ~trace_only & (brt_ev | trap_ev | (vc_ev & ~async_addr_cmp_sel));

   // Imprecise record plays out once the debug interrupt is allowed again
   assign delayed_irq = int_only & dbg_irq_allow_q & ~allow_prev_q
                        & debug_status_reg_q[st_imprecise]
                        & (debug_status_reg_q[st_trap] | (|debug_status_reg_q[3:0]));

   always_comb begin
      status_set = 7'h00;
      status_set[st_a_read] = vc_a & any_mode & ~acc_wr;
      status_set[st_a_write] = vc_a & any_mode & acc_wr;
      status_set[st_b_read] = vc_b & any_mode & ~acc_wr;
      status_set[st_b_write] = vc_b & any_mode & acc_wr;
      status_set[st_brt] = brt_ev;
      status_set[st_trap] = trap_ev;
      status_set[st_imprecise] = int_only & ~dbg_irq_allow_q & (trap_ev | vc_ev);
   end

   // ****************************************************************
   // Debug actions
   // ****************************************************************
   // Stop state for the external debugger, PC at the offending instruction
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stop_req_q <= 1'b0;
         stop_pc_q <= '0;
      end else begin
         stop_req_q <= dbg_mode & ev_any;
         if (dbg_mode & ev_any) begin
            stop_pc_q <= ins_pc;
         end
      end
   end

   // Debug interrupt, immediate or delayed, and the trap-type program interrupt
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dbg_irq_q <= 1'b0;
         prog_trap_q <= 1'b0;
         csave_q <= '0;
      end else begin
         dbg_irq_q <= (int_only & dbg_irq_allow_q & ev_any) | delayed_irq;
         prog_trap_q <= int_only & ~dbg_irq_allow_q & trap_ev;
         if (int_only & dbg_irq_allow_q & ev_any) begin
            csave_q <= ins_pc;
         end
      end
   end

   // Suppression and trace; trace mode never holds up execution
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         suppress_q <= 1'b0;
         trace_valid_q <= 1'b0;
         trace_code_q <= 3'b000;
      end else begin
         suppress_q <= ev_supp;
         trace_valid_q <= trace_only & ev_any;
         trace_code_q <= trace_only ? {vc_ev, trap_ev, brt_ev} : 3'b000;
      end
   end

   // ****************************************************************
   // Avalon-MM slave
   // ****************************************************************
   logic req;
   logic wr_fire;

   assign req = avs_read | avs_write;
   // Write lands at the edge where the master sees waitrequest low
   assign wr_fire = avs_write & ~wait_q;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   // One wait cycle per access; the slave releases for exactly one cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= ~(req & wait_q);
      end
   end

   // Read mux, captured while waitrequest is still high
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= 32'h0000_0000;
      end else if (avs_read & wait_q) begin
         case (avs_address)
            ctrl_zero_off: rdata_q <= {26'h0, debug_ctrl_zero_q};
            ctrl_two_off: rdata_q <= {19'h0, debug_ctrl_two_q};
            cmp_a_off: rdata_q <= value_cmp_reg_a_q;
            cmp_b_off: rdata_q <= value_cmp_reg_b_q;
            status_off: rdata_q <= {25'h0, debug_status_reg_q};
            msr_off: rdata_q <= {31'h0, dbg_irq_allow_q};
            csave_off: rdata_q <= 32'(csave_q);
            default: rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // Control and compare registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         debug_ctrl_zero_q <= ctrl_zero_rst;
         debug_ctrl_two_q <= ctrl_two_rst;
         value_cmp_reg_a_q <= 32'h0000_0000;
         value_cmp_reg_b_q <= 32'h0000_0000;
         dbg_irq_allow_q <= 1'b0;
      end else if (wr_fire) begin
         case (avs_address)
            ctrl_zero_off: debug_ctrl_zero_q <= 6'(merge({26'h0, debug_ctrl_zero_q},
                                                         avs_writedata, avs_byteenable));
            ctrl_two_off: debug_ctrl_two_q <= 13'(merge({19'h0, debug_ctrl_two_q},
                                                        avs_writedata, avs_byteenable));
            cmp_a_off: value_cmp_reg_a_q <= merge(value_cmp_reg_a_q, avs_writedata,
                                                  avs_byteenable);
            cmp_b_off: value_cmp_reg_b_q <= merge(value_cmp_reg_b_q, avs_writedata,
                                                  avs_byteenable);
            msr_off: begin
               if (avs_byteenable[0]) begin
                  dbg_irq_allow_q <= avs_writedata[0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Allow edge detector for the delayed interrupt
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         allow_prev_q <= 1'b0;
      end else begin
         allow_prev_q <= dbg_irq_allow_q;
      end
   end

   // Status: write one to clear, a new event in the same cycle wins
   logic [6:0] status_clr;
   assign status_clr = (wr_fire && avs_address == status_off && avs_byteenable[0])
                       ? avs_writedata[6:0] : 7'h00;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         debug_status_reg_q <= status_rst;
      end else begin
         debug_status_reg_q <= (debug_status_reg_q & ~status_clr) | status_set;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
   assign suppress = suppress_q;
   assign stop_req = stop_req_q;
   assign stop_pc = stop_pc_q;
   assign dbg_irq = dbg_irq_q;
   assign prog_trap_irq = prog_trap_q;
   assign critical_save_pc = csave_q;
   assign trace_valid = trace_valid_q;
   assign trace_code = trace_code_q;

endmodule

// File: dbg_event_pkg.sv
// How it works
// - Mode 01 matches only if every enabled lane is accessed and equal.
// - Mode 10 matches if any enabled lane is accessed and equal.
// - Mode 11 runs the all-lanes test per lane pair, either pair matching.
// - Select bit 0 handles value events synchronously, 1 asynchronously.
// - Each storage access of one instruction is judged on its own.
// - Only cache-line-zero counts among cache ops, as a write of zeroes.
// - A conditional store without reservation raises no write value event.
// - Indexed string ops with byte count zero raise no value event.
// - Taken branch with its enable set raises a taken-branch event in every mode but internal alone with irq disallowed.
// - External or wait mode: branch status set, suppressed, stop at branch.
// - Internal mode, irq allowed: branch status set, suppressed, debug irq.
// - Internal mode alone, irq disallowed: no taken-branch events.
// - Trace mode: branch status set, trace signalled, execution goes on.
// - Satisfied trap op with its enable set raises a trap event.
// - External or wait mode: trap status set, suppressed, stop at trap.
// - Internal mode, irq allowed: trap status set, suppressed, debug irq.
// - Internal alone, irq disallowed: trap and imprecise set, program trap.
// - Recorded imprecise trap gives debug irq when allow rises, unless cleared.
// - Trace mode: trap status set, trace signalled, execution goes on.
// - All-zero lane mask disables that value event; nonzero enables it unless its mode is 00.
// - Value events set the shared address-compare read/write status bits.
// - Mask bit 3 is lane 0, the most significant byte; lane must be sent.
// - Only lanes inside the aligned word of the starting byte are compared.
package dbg_event_pkg;

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [4:0] ctrl_zero_off = 5'h00;
   localparam logic [4:0] ctrl_two_off = 5'h04;
   localparam logic [4:0] cmp_a_off = 5'h08;
   localparam logic [4:0] cmp_b_off = 5'h0c;
   localparam logic [4:0] status_off = 5'h10;
   localparam logic [4:0] msr_off = 5'h14;
   localparam logic [4:0] csave_off = 5'h18;

   // debug_ctrl_zero fields
   localparam int brt_en_bit = 0;
   localparam int trap_en_bit = 1;
   localparam int ext_mode_bit = 2;
   localparam int wait_mode_bit = 3;
   localparam int int_mode_bit = 4;
   localparam int trace_mode_bit = 5;
   localparam logic [5:0] ctrl_zero_rst = 6'h00;

   // debug_ctrl_two fields
   localparam int mask_a_lsb = 0;
   localparam int mask_b_lsb = 4;
   localparam int mode_a_lsb = 8;
   localparam int mode_b_lsb = 10;
   localparam int async_sel_bit = 12;
   localparam logic [12:0] ctrl_two_rst = 13'h0000;

   // debug_status_reg fields
   localparam int st_a_read = 0;
   localparam int st_a_write = 1;
   localparam int st_b_read = 2;
   localparam int st_b_write = 3;
   localparam int st_brt = 4;
   localparam int st_trap = 5;
   localparam int st_imprecise = 6;
   localparam logic [6:0] status_rst = 7'h00;

   // Compare modes and cache line size
   localparam logic [1:0] mode_off = 2'b00;
   localparam logic [1:0] mode_and = 2'b01;
   localparam logic [1:0] mode_or = 2'b10;
   localparam logic [1:0] mode_and_or = 2'b11;
   localparam int cache_line_bytes = 32;

endpackage

// File: dbg_event_unit_chk.sv
`timescale 1ns/1ps
// ****************************************************************
// Port-level checks on the debug action outputs
// ****************************************************************
module dbg_event_unit_chk #(
   parameter int pc_width = 32
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic acc_valid,
   input wire logic [pc_width-1:0] ins_pc,
   input wire logic branch_taken,
   input wire logic trap_word_op,
   input wire logic suppress,
   input wire logic stop_req,
   input wire logic [pc_width-1:0] stop_pc,
   input wire logic dbg_irq,
   input wire logic prog_trap_irq,
   input wire logic [pc_width-1:0] critical_save_pc,
   input wire logic trace_valid,
   input wire logic [2:0] trace_code
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   // A request seen with waitrequest high is answered within two edges
   a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
      |-> ##[1:2] !avs_waitrequest) else $error("bus answer late");
   a_stop_pc: assert property (stop_req |-> stop_pc == $past(ins_pc))
      else $error("stop pc not the event address");
   // A suppressed event that raises the debug irq loads the save pc; a delayed irq never does
   a_irq_save_pc: assert property (dbg_irq && suppress
      |-> critical_save_pc == $past(ins_pc)) else $error("save pc not the event address");
   a_stop_alone: assert property (stop_req |-> !dbg_irq && !trace_valid
      && !prog_trap_irq) else $error("stop mixed with other action");
   a_prog_trap: assert property (prog_trap_irq |-> suppress && !dbg_irq
      && $past(trap_word_op)) else $error("program trap without suppressed trap");
   // Actions other than the debug irq never appear without a cause on the previous edge
   a_quiet_idle: assert property (!$past(acc_valid | branch_taken | trap_word_op)
      |-> !suppress && !stop_req && !prog_trap_irq && !trace_valid)
      else $error("action without cause");
   a_trace_free: assert property (trace_valid |-> !suppress && !stop_req
      && !dbg_irq) else $error("trace event halted execution");
   a_trace_branch: assert property (trace_valid && $past(branch_taken && !trap_word_op
      && !acc_valid) |-> trace_code == 3'b001) else $error("trace code wrong for branch");
   a_trace_trap: assert property (trace_valid && $past(trap_word_op && !branch_taken
      && !acc_valid) |-> trace_code == 3'b010) else $error("trace code wrong for trap");

   // Main scenarios reached
   c_stop: cover property (stop_req);
   c_prog: cover property (prog_trap_irq);
   c_trace: cover property (trace_valid);
endmodule

bind dbg_event_unit dbg_event_unit_chk #(.pc_width(pc_width)) chk_i (.clk, .resetn, .avs_read,
   .avs_write, .avs_waitrequest, .acc_valid, .ins_pc, .branch_taken, .trap_word_op, .suppress,
   .stop_req, .stop_pc, .dbg_irq, .prog_trap_irq, .critical_save_pc, .trace_valid, .trace_code);

// File: pipe_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Pipeline side: one access or outcome per call
// ****************************************************************
module pipe_model (
   input wire logic clk,
   output logic acc_valid,
   output logic acc_is_write,
   output logic [1:0] acc_offset,
   output logic [2:0] acc_len,
   output logic [31:0] acc_data,
   output logic acc_addr_hit_a,
   output logic acc_addr_hit_b,
   output logic acc_cache_op,
   output logic acc_cache_zero,
   output logic acc_store_cond,
   output logic acc_reservation,
   output logic acc_string_idx,
   output logic [6:0] string_byte_count,
   output logic [31:0] ins_pc,
   output logic branch_taken,
   output logic trap_word_op
);
   // Quiet pipeline at time zero
   initial begin
      {acc_valid, acc_is_write, acc_offset, acc_len, acc_data} = '0;
      {acc_addr_hit_a, acc_addr_hit_b, acc_cache_op, acc_cache_zero} = '0;
      {acc_store_cond, acc_reservation, acc_string_idx, string_byte_count} = '0;
      {ins_pc, branch_taken, trap_word_op} = '0;
   end

   // Kind: 0 plain, 1 line zero on b, 2 store cond lost, 3 empty string, 4 no hit, 5 cond held
   task automatic acc(input logic w, input logic [1:0] off, input logic [2:0] len,
                      input logic [31:0] d, input logic [2:0] k);
      @(posedge clk);
      acc_valid <= 1'b1;
      acc_is_write <= w;
      acc_offset <= off;
      acc_len <= len;
      acc_data <= d;
      acc_addr_hit_a <= (k != 3'd1) && (k != 3'd4);
      acc_addr_hit_b <= (k == 3'd1);
      acc_cache_op <= (k == 3'd1);
      acc_cache_zero <= (k == 3'd1);
      acc_store_cond <= (k == 3'd2) || (k == 3'd5);
      acc_reservation <= (k == 3'd5);
      acc_string_idx <= (k == 3'd3);
      string_byte_count <= (k == 3'd3) ? 7'h00 : 7'h04;
      @(posedge clk);
      acc_valid <= 1'b0;
      acc_data <= ~d; // Released data must not look valid
   endtask

   task automatic ev(input logic br, input logic tr, input logic [31:0] pc);
      @(posedge clk);
      ins_pc <= pc;
      branch_taken <= br;
      trap_word_op <= tr;
      @(posedge clk);
      branch_taken <= 1'b0;
      trap_word_op <= 1'b0;
   endtask
endmodule

// File: dbg_event_unit_test.sv
`timescale 1ns/1ps
module dbg_event_unit_test;
   import dbg_event_pkg::*;
   logic clk, resetn, avs_read, avs_write, avs_waitrequest;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rdat, acc_data, ins_pc, stop_pc, critical_save_pc;
   logic [3:0] avs_byteenable;
   logic acc_valid, acc_is_write, acc_addr_hit_a, acc_addr_hit_b, acc_cache_op, acc_cache_zero;
   logic acc_store_cond, acc_reservation, acc_string_idx, branch_taken, trap_word_op;
   logic [1:0] acc_offset;
   logic [2:0] acc_len, trace_code;
   logic [6:0] string_byte_count;
   logic suppress, stop_req, dbg_irq, prog_trap_irq, trace_valid;
   int fails, n_checks;

   dbg_event_unit DUT (.clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .acc_valid, .acc_is_write, .acc_offset,
      .acc_len, .acc_data, .acc_addr_hit_a, .acc_addr_hit_b, .acc_cache_op, .acc_cache_zero,
      .acc_store_cond, .acc_reservation, .acc_string_idx, .string_byte_count, .ins_pc,
      .branch_taken, .trap_word_op, .suppress, .stop_req, .stop_pc, .dbg_irq, .prog_trap_irq,
      .critical_save_pc, .trace_valid, .trace_code);
   pipe_model PIPE (.clk, .acc_valid, .acc_is_write, .acc_offset, .acc_len, .acc_data,
      .acc_addr_hit_a, .acc_addr_hit_b, .acc_cache_op, .acc_cache_zero, .acc_store_cond, .ins_pc,
      .acc_reservation, .acc_string_idx, .string_byte_count, .branch_taken, .trap_word_op);

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One bus access; held until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      rdat = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 20) begin
         fails++;
         wrap_up();
      end
   endtask

   // Branch or trap in one mode; e is {suppress, stop, irq, program trap, trace}
   task automatic tk(input logic [5:0] c0, input logic al, input logic br,
                     input logic [4:0] e, input logic [6:0] st);
      logic [31:0] pc;
      pc = {16'h0, 8'ha0, 1'b0, c0, br};
      bus(1'b1, status_off, 32'h7f);
      bus(1'b1, ctrl_zero_off, {26'h0, c0});
      bus(1'b1, msr_off, {31'h0, al});
      PIPE.ev(br, !br, pc);
      #1;
      cmp({27'h0, suppress, stop_req, dbg_irq, prog_trap_irq, trace_valid}, {27'h0, e});
      if (e[3]) cmp(stop_pc, pc);
      if (e[2]) cmp(critical_save_pc, pc);
      bus(1'b0, status_off, 32'h0);
      cmp(rdat, {25'h0, st});
   endtask

   // Delayed interrupt looked for in a short window, a pulse is enough
   task automatic irq_wait(input logic exp);
      logic hit = 1'b0;
      for (int n = 0; n < 6; n++) begin
         @(posedge clk);
         #1;
         if (dbg_irq === 1'b1) hit = 1'b1;
      end
      cmp({31'h0, hit}, {31'h0, exp});
   endtask

   // One access against comparator settings; st is the expected status
   task automatic vc(input logic [12:0] c2, input logic w, input logic [1:0] off,
                     input logic [2:0] len, input logic [31:0] d, input logic [2:0] k,
                     input logic [6:0] st);
      bus(1'b1, status_off, 32'h7f);
      bus(1'b1, ctrl_two_off, {19'h0, c2});
      PIPE.acc(w, off, len, d, k);
      #1;
      cmp({30'h0, suppress, dbg_irq}, {30'h0, (st != 7'h0) && !c2[12], st != 7'h0});
      bus(1'b0, status_off, 32'h0);
      cmp(rdat, {25'h0, st});
   endtask

   // ****************************************************************
   // Clock and main sequence
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial begin
      {resetn, avs_read, avs_write, avs_address, avs_writedata} = '0;
      avs_byteenable = 4'hf;
      fails = 0;
      n_checks = 0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      // Every register and the unmapped slot read zero after reset
      for (int a = 0; a < 8; a++) begin
         bus(1'b0, 5'(a * 4), 32'h0);
         cmp(rdat, 32'h0);
      end
      bus(1'b1, ctrl_two_off, 32'hffffffff);
      bus(1'b0, ctrl_two_off, 32'h0);
      cmp(rdat, 32'h00001fff);
      bus(1'b1, 5'h1c, 32'h12345678);
      bus(1'b0, 5'h1c, 32'h0);
      cmp(rdat, 32'h0);
      tk(6'h05, 1'b0, 1'b1, 5'b11000, 7'h10);
      tk(6'h09, 1'b0, 1'b1, 5'b11000, 7'h10);
      tk(6'h11, 1'b1, 1'b1, 5'b10100, 7'h10);
      tk(6'h11, 1'b0, 1'b1, 5'b00000, 7'h00);
      tk(6'h21, 1'b0, 1'b1, 5'b00001, 7'h10);
      tk(6'h24, 1'b0, 1'b1, 5'b00000, 7'h00);
      tk(6'h06, 1'b0, 1'b0, 5'b11000, 7'h20);
      tk(6'h0a, 1'b1, 1'b0, 5'b11000, 7'h20);
      tk(6'h12, 1'b1, 1'b0, 5'b10100, 7'h20);
      tk(6'h22, 1'b0, 1'b0, 5'b00001, 7'h20);
      tk(6'h11, 1'b1, 1'b0, 5'b00000, 7'h00);
      tk(6'h12, 1'b0, 1'b0, 5'b10010, 7'h60);
      bus(1'b1, msr_off, 32'h1);
      irq_wait(1'b1);
      tk(6'h12, 1'b0, 1'b0, 5'b10010, 7'h60);
      bus(1'b1, status_off, 32'h7f);
      bus(1'b1, msr_off, 32'h1);
      irq_wait(1'b0);
      // Value compares in internal mode with interrupts allowed
      bus(1'b1, ctrl_zero_off, 32'h10);
      bus(1'b1, cmp_a_off, 32'h11223344);
      bus(1'b1, cmp_b_off, 32'h0);
      vc(13'h010f, 1'b0, 2'd0, 3'd4, 32'h11223344, 3'd0, 7'h01);
      vc(13'h010f, 1'b0, 2'd0, 3'd4, 32'h11223300, 3'd0, 7'h00);
      vc(13'h010f, 1'b0, 2'd1, 3'd4, 32'h00223344, 3'd0, 7'h00);
      vc(13'h020f, 1'b0, 2'd1, 3'd4, 32'h00223344, 3'd0, 7'h01);
      vc(13'h0208, 1'b0, 2'd1, 3'd3, 32'h11223344, 3'd0, 7'h00);
      vc(13'h0103, 1'b0, 2'd2, 3'd2, 32'h00003344, 3'd0, 7'h01);
      vc(13'h030f, 1'b0, 2'd0, 3'd4, 32'h11220000, 3'd0, 7'h01);
      vc(13'h030f, 1'b0, 2'd0, 3'd4, 32'h11003300, 3'd0, 7'h00);
      vc(13'h000f, 1'b0, 2'd0, 3'd4, 32'h11223344, 3'd0, 7'h00);
      vc(13'h0100, 1'b0, 2'd0, 3'd4, 32'h11223344, 3'd0, 7'h00);
      vc(13'h010f, 1'b1, 2'd0, 3'd4, 32'h11223344, 3'd0, 7'h02);
      vc(13'h04f0, 1'b1, 2'd0, 3'd4, 32'hffffffff, 3'd1, 7'h08);
      vc(13'h010f, 1'b1, 2'd0, 3'd4, 32'h11223344, 3'd2, 7'h00);
      vc(13'h010f, 1'b1, 2'd0, 3'd4, 32'h11223344, 3'd5, 7'h02);
      vc(13'h010f, 1'b0, 2'd0, 3'd4, 32'h11223344, 3'd3, 7'h00);
      vc(13'h010f, 1'b0, 2'd0, 3'd4, 32'h11223344, 3'd4, 7'h00);
      vc(13'h110f, 1'b0, 2'd0, 3'd4, 32'h11223344, 3'd0, 7'h01);
      wrap_up();
   end
endmodule
